// ==== rtl/tpc_pkg.sv ====
/*
  Constants and types for the 16-bit timer reset, trigger-clear and
  prescale control block: register indices, field positions, reset values.
  Assumes register indices are word indices on APB (byte address = 4*index).
*/
`default_nettype none

package tpc_pkg;

  // register word indices; byte address is four times the index
  localparam logic [7:0] IDX_GLOBAL_IRQ_CTRL = 8'h0B;
  localparam logic [7:0] IDX_PERIPH_FLAGS    = 8'h0C;
  localparam logic [7:0] IDX_COUNTER_LOW     = 8'h0E;
  localparam logic [7:0] IDX_COUNTER_HIGH    = 8'h0F;
  localparam logic [7:0] IDX_COUNTER_CTRL    = 8'h10;
  localparam logic [7:0] IDX_PERIPH_ENABLES  = 8'h8C;

  // field positions
  localparam int GLOBAL_IRQ_ENABLE_BIT     = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int OVERFLOW_FLAG_BIT         = 0;
  localparam int OVERFLOW_IRQ_ENABLE_BIT   = 0;
  localparam int CTRL_W                    = 6;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET        = 6'h00;
  localparam logic [7:0]        GLOBAL_IRQ_RESET  = 8'h00;
  // bits of the global control kept by a non-power-on reset
  localparam logic [7:0]        GLOBAL_IRQ_KEEP   = 8'h01;
  localparam logic [2:0]        PRESCALE_RESET    = 3'h0;

  // compare unit mode code that requests the special event trigger
  localparam logic [3:0]  SPECIAL_EVENT_MODE = 4'hB;
  localparam logic [15:0] COUNTER_TOP        = 16'hFFFF;

  typedef struct packed {
    logic [1:0] prescale_select;
    logic       aux_oscillator_enable;
    logic       external_sync_disable;
    logic       clock_source_select;
    logic       counter_run;
  } tpc_ctrl_s;

endpackage : tpc_pkg

`default_nettype wire

// ==== rtl/tpc_timer.sv ====
/*
  16-bit timer/counter core with prescaler, special event trigger clear,
  overflow flag and interrupt, behind an APB slave.
  Assumes: reset is power-on/brown-out; other_reset is a one-cycle
  synchronous pulse for every other reset source; ext_clk_in and sleep are
  synchronous to clk; clk is the instruction clock.
*/
// Chosen here: the APB slave port.
// Behaviour
// - compare mode 1011 with a match fires the trigger that clears the counter
// - a trigger clear never sets the overflow flag
// - a counter byte write in the trigger cycle wins over the clear
// - with trigger clear the counter runs zero to compare value, then restarts
// - counter bytes survive every reset; only the trigger and the rollover past FFFF clear them
// - power-on/brown-out zeroes the control register; other resets keep it
// - any counter byte write zeroes the prescaler count
// - internal clock source counts instruction cycles; sync control ignored
// - external mode counts rising edges, first only after a falling edge
// - asynchronous counter mode keeps counting in sleep and can wake
`timescale 1ns/100ps
`default_nettype none

module tpc_timer
  import tpc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              other_reset,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_clk_in,
  input  wire logic              sleep,
  input  wire logic [3:0]        compare_mode_field,
  input  wire logic [7:0]        compare_value_high,
  input  wire logic [7:0]        compare_value_low,
  output logic                   special_event_trigger,
  output logic                   aux_oscillator_enable,
  output logic                   irq,
  output logic                   wake
);

  tpc_ctrl_s   counter_control_ff;
  tpc_ctrl_s   nxt_counter_control;
  logic [7:0]  global_irq_ff;
  logic [7:0]  nxt_global_irq;
  logic        overflow_flag_ff;
  logic        nxt_overflow_flag;
  logic        overflow_irq_enable_ff;
  logic        nxt_overflow_irq_enable;
  logic [15:0] counter_ff;
  logic [15:0] nxt_counter;
  logic [2:0]  prescale_ff;
  logic [2:0]  nxt_prescale;
  logic        ext_q_ff;
  logic        armed_ff;
  logic        nxt_armed;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  // bus decode
  wire         upper_zero  = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0);
  wire  [7:0]  word_idx    = paddr[9:2];
  wire         sel_gic     = upper_zero && (word_idx == IDX_GLOBAL_IRQ_CTRL);
  wire         sel_flags   = upper_zero && (word_idx == IDX_PERIPH_FLAGS);
  wire         sel_low     = upper_zero && (word_idx == IDX_COUNTER_LOW);
  wire         sel_high    = upper_zero && (word_idx == IDX_COUNTER_HIGH);
  wire         sel_ctrl    = upper_zero && (word_idx == IDX_COUNTER_CTRL);
  wire         sel_enables = upper_zero && (word_idx == IDX_PERIPH_ENABLES);
  wire         hit         = sel_gic | sel_flags | sel_low | sel_high
                             | sel_ctrl | sel_enables;
  wire         access      = psel && penable;
  wire         wr_en       = access && pwrite && pstrb[0] && hit;
  wire         rd_setup    = psel && !penable && !pwrite;
  wire         rd_flags    = access && !pwrite && sel_flags;
  wire         wr_gic      = wr_en && sel_gic;
  wire         wr_flags    = wr_en && sel_flags;
  wire         wr_low      = wr_en && sel_low;
  wire         wr_high     = wr_en && sel_high;
  wire         wr_ctrl     = wr_en && sel_ctrl;
  wire         wr_enables  = wr_en && sel_enables;
  wire         cnt_wr      = wr_low || wr_high;

  wire  [7:0]  rd_mux =
    sel_gic     ? global_irq_ff :
    sel_flags   ? {7'h00, overflow_flag_ff} :
    sel_low     ? counter_ff[7:0] :
    sel_high    ? counter_ff[15:8] :
    sel_ctrl    ? {2'h0, counter_control_ff} :
    sel_enables ? {7'h00, overflow_irq_enable_ff} : 8'h00;

  assign nxt_prdata = rd_setup ? {24'h000000, rd_mux} : prdata_ff;
  assign prdata     = prdata_ff;
  // zero wait states; the read value is latched in the setup cycle
  assign pready     = 1'b1;
  assign pslverr    = access && !hit;

  // clock source and prescaler
  wire         run       = counter_control_ff.counter_run;
  wire         ext_mode  = counter_control_ff.clock_source_select;
  wire         async_cnt = ext_mode && counter_control_ff.external_sync_disable;
  wire         ext_rise  = ext_clk_in && !ext_q_ff;
  wire         ext_fall  = !ext_clk_in && ext_q_ff;
  // instruction clock stops in sleep, so the internal source is gated by it
  wire         src_edge  = ext_mode ? (ext_rise && armed_ff) : !sleep;
  wire  [2:0]  ratio_m1  =
    (counter_control_ff.prescale_select == 2'h0) ? 3'h0 :
    (counter_control_ff.prescale_select == 2'h1) ? 3'h1 :
    (counter_control_ff.prescale_select == 2'h2) ? 3'h3 : 3'h7;
  wire         pre_step  = run && src_edge;
  wire         pre_wrap  = pre_step && (prescale_ff == ratio_m1);
  // synchronized mode stalls in sleep; the ripple prescaler keeps going
  wire         tick      = pre_wrap && (!sleep || async_cnt);

  assign nxt_prescale =
    cnt_wr   ? PRESCALE_RESET :
    pre_wrap ? PRESCALE_RESET :
    pre_step ? 3'(prescale_ff + 3'h1) : prescale_ff;

  // armed only after a falling edge seen while enabled in counter mode
  assign nxt_armed = !(run && ext_mode) ? 1'b0 :
                     ext_fall           ? 1'b1 : armed_ff;

  // special event trigger and counter
  wire  [15:0] compare_value = {compare_value_high, compare_value_low};
  wire         special_mode  = (compare_mode_field == SPECIAL_EVENT_MODE);
  // match on the tick that would leave the compare value: period is value+1
  wire         special_evt   = special_mode && tick
                               && (counter_ff == compare_value);
  wire         rollover      = tick && (counter_ff == COUNTER_TOP);
  wire  [15:0] cnt_inc       = 16'(counter_ff + 16'h0001);

  assign special_event_trigger = special_evt;

  assign nxt_counter =
    wr_low      ? {counter_ff[15:8], pwdata[7:0]} :
    wr_high     ? {pwdata[7:0], counter_ff[7:0]} :
    special_evt ? 16'h0000 :
    tick        ? cnt_inc : counter_ff;

  // flag: hardware set wins over read clear and over a software write of 0
  wire         ovf_set  = rollover && !special_evt && !cnt_wr;
  // a read clears only what it actually returned
  wire         ovf_keep = wr_flags ? pwdata[OVERFLOW_FLAG_BIT] :
                          (overflow_flag_ff && !(rd_flags && prdata_ff[0]));
  assign nxt_overflow_flag = other_reset ? ovf_set : (ovf_set || ovf_keep);

  assign nxt_overflow_irq_enable =
    other_reset ? 1'b0 :
    wr_enables  ? pwdata[OVERFLOW_IRQ_ENABLE_BIT] : overflow_irq_enable_ff;

  assign nxt_global_irq =
    other_reset ? (global_irq_ff & GLOBAL_IRQ_KEEP) :
    wr_gic      ? pwdata[7:0] : global_irq_ff;

  // other resets leave the control register as it is
  assign nxt_counter_control =
    wr_ctrl ? tpc_ctrl_s'(pwdata[CTRL_W-1:0]) : counter_control_ff;

  wire         pending = overflow_flag_ff && overflow_irq_enable_ff;
  assign wake  = pending;
  assign irq   = pending && global_irq_ff[GLOBAL_IRQ_ENABLE_BIT]
                 && global_irq_ff[PERIPHERAL_IRQ_ENABLE_BIT];
  assign aux_oscillator_enable = counter_control_ff.aux_oscillator_enable;

  // reset input is power-on/brown-out only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      counter_control_ff     <= tpc_ctrl_s'(CTRL_RESET);
      global_irq_ff          <= GLOBAL_IRQ_RESET;
      overflow_flag_ff       <= 1'b0;
      overflow_irq_enable_ff <= 1'b0;
      prescale_ff            <= PRESCALE_RESET;
      ext_q_ff               <= 1'b0;
      armed_ff               <= 1'b0;
      prdata_ff              <= 32'h00000000;
    end else begin
      counter_control_ff     <= nxt_counter_control;
      global_irq_ff          <= nxt_global_irq;
      overflow_flag_ff       <= nxt_overflow_flag;
      overflow_irq_enable_ff <= nxt_overflow_irq_enable;
      prescale_ff            <= nxt_prescale;
      ext_q_ff               <= ext_clk_in;
      armed_ff               <= nxt_armed;
      prdata_ff              <= nxt_prdata;
    end
  end

  // no reset at all: contents are unknown until first written
  always_ff @(posedge clk) begin
    counter_ff <= nxt_counter;
  end

  trig_clear_a: assert property (
    @(posedge clk) disable iff (reset)
    special_evt && !cnt_wr |=> counter_ff == 16'h0000)
    else $error("trigger did not clear the counter");

  no_trig_flag_a: assert property (
    @(posedge clk) disable iff (reset)
    special_evt && !wr_flags |=> !$rose(overflow_flag_ff))
    else $error("trigger clear set the overflow flag");

  write_wins_a: assert property (
    @(posedge clk) disable iff (reset)
    wr_low && special_evt |=> counter_ff[7:0] == $past(pwdata[7:0]))
    else $error("trigger overrode a counter write");

  period_wrap_a: assert property (
    @(posedge clk) disable iff (reset)
    special_mode && tick && !cnt_wr && counter_ff == compare_value
    |=> counter_ff == 16'h0000
    ##0 (!special_event_trigger || compare_value == 16'h0000))
    else $error("counter passed the compare value");

  cnt_retain_a: assert property (
    @(posedge clk) disable iff (reset)
    other_reset && !tick && !cnt_wr |=> $stable(counter_ff))
    else $error("counter changed on a reset");

  ctrl_retain_a: assert property (
    @(posedge clk) disable iff (reset)
    other_reset && !wr_ctrl |=> $stable(counter_control_ff))
    else $error("control register changed on a reset");

  presc_clear_a: assert property (
    @(posedge clk) disable iff (reset)
    cnt_wr |=> prescale_ff == 3'h0)
    else $error("prescaler not cleared by counter write");

  timer_count_a: assert property (
    @(posedge clk) disable iff (reset)
    run && !ext_mode && !sleep && !cnt_wr && !special_evt
    && counter_control_ff.prescale_select == 2'h0 && prescale_ff == 3'h0
    |=> counter_ff == 16'($past(counter_ff) + 16'h0001))
    else $error("timer mode missed an instruction cycle");

  first_edge_a: assert property (
    @(posedge clk) disable iff (reset)
    ext_mode && !armed_ff && !cnt_wr |=> $stable(counter_ff))
    else $error("counted before a falling edge was seen");

  async_sleep_a: assert property (
    @(posedge clk) disable iff (reset)
    sleep && async_cnt && pre_wrap |-> tick)
    else $error("asynchronous counter stalled in sleep");

  overflow_set_a: assert property (
    @(posedge clk) disable iff (reset)
    rollover && !special_evt && !cnt_wr |=> overflow_flag_ff [*1]
    ##0 counter_ff == 16'h0000)
    else $error("rollover did not set the overflow flag");

  // bus side: zero wait states, error only inside an access phase
  pready_high_a: assert property (
    @(posedge clk) disable iff (reset)
    psel |-> pready)
    else $error("slave inserted a wait state");

  slverr_scope_a: assert property (
    @(posedge clk) disable iff (reset)
    pslverr |-> psel && penable)
    else $error("error response outside an access phase");

  rdata_upper_a: assert property (
    @(posedge clk) disable iff (reset)
    1'b1 |-> prdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  // flag and interrupt level behaviour
  flag_rdclr_a: assert property (
    @(posedge clk) disable iff (reset)
    rd_flags && prdata_ff[0] && !rollover && !wr_flags |=> !overflow_flag_ff)
    else $error("flag not cleared by its read");

  flag_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    overflow_flag_ff && !rd_flags && !wr_flags && !other_reset
    |=> overflow_flag_ff)
    else $error("overflow flag dropped by itself");

  ovf_cause_a: assert property (
    @(posedge clk) disable iff (reset)
    $rose(overflow_flag_ff) && !$past(wr_flags) |-> $past(rollover))
    else $error("overflow flag set without a rollover");

  irq_level_a: assert property (
    @(posedge clk) disable iff (reset)
    irq |-> overflow_flag_ff && overflow_irq_enable_ff)
    else $error("interrupt without an enabled flag");

  wake_level_a: assert property (
    @(posedge clk) disable iff (reset)
    overflow_flag_ff && overflow_irq_enable_ff |-> wake)
    else $error("enabled flag did not request wake");

  // trigger generation and counter high byte write
  trig_tick_a: assert property (
    @(posedge clk) disable iff (reset)
    special_event_trigger |-> tick && special_mode)
    else $error("trigger without a counting tick");

  trig_mode_a: assert property (
    @(posedge clk) disable iff (reset)
    !special_mode |-> !special_event_trigger)
    else $error("trigger outside special event mode");

  high_write_a: assert property (
    @(posedge clk) disable iff (reset)
    wr_high |=> counter_ff[15:8] == $past(pwdata[7:0]))
    else $error("high byte write lost");

  // clock sources and sleep
  int_sleep_a: assert property (
    @(posedge clk) disable iff (reset)
    sleep && !ext_mode |-> !pre_step)
    else $error("internal source stepped in sleep");

  sync_stall_a: assert property (
    @(posedge clk) disable iff (reset)
    sleep && ext_mode && !async_cnt |-> !tick)
    else $error("synchronized counter ticked in sleep");

  arm_drop_a: assert property (
    @(posedge clk) disable iff (reset)
    !(run && ext_mode) |=> !armed_ff)
    else $error("edge arming kept outside counter mode");

  // register writes and reset retention
  ctrl_write_a: assert property (
    @(posedge clk) disable iff (reset)
    wr_ctrl |=> {counter_control_ff} == $past(pwdata[CTRL_W-1:0]))
    else $error("control write lost");

  gic_keep_a: assert property (
    @(posedge clk) disable iff (reset)
    other_reset && !wr_gic
    |=> global_irq_ff == ($past(global_irq_ff) & GLOBAL_IRQ_KEEP))
    else $error("global control wrong after a reset");

endmodule // tpc_timer

`default_nettype wire

// ==== tb/tpc_cmp_model.sv ====
/*
  Compare unit stand-in: holds mode code and 16-bit compare value.
  Assumes the bench sets cfg_mode and cfg_value at a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module tpc_cmp_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  cfg_mode,
  input  wire logic [15:0] cfg_value,
  output logic      [3:0]  compare_mode_field,
  output logic      [7:0]  compare_value_high,
  output logic      [7:0]  compare_value_low
);
  logic [3:0]  mode_ff;
  logic [15:0] value_ff;
  // trigger mode is only asked for while the timer counts clk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_ff  <= 4'h0;
      value_ff <= 16'hFFFF;
    end else begin
      mode_ff  <= cfg_mode;
      value_ff <= cfg_value;
    end
  end
  assign compare_mode_field = mode_ff;
  assign {compare_value_high, compare_value_low} = value_ff;
endmodule // tpc_cmp_model
`default_nettype wire

// ==== tb/testbench.sv ====
/*
  Self-checking bench for tpc_timer over APB with a compare unit model.
  Assumes zero or more wait states; one 200 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tpc_pkg::*;
  logic clk, reset, other_reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb, cfg_mode, cmode;
  logic [15:0] cfg_value;
  logic [7:0] cvh, cvl;
  logic trig, aux, irq, wake, errv, ext_clk, slp;
  int n_errors = 0, n_checks = 0, trig_cnt = 0, g;

  tpc_timer dut_u (.clk(clk), .reset(reset), .other_reset(other_reset),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_in(ext_clk), .sleep(slp),
    .compare_mode_field(cmode), .compare_value_high(cvh),
    .compare_value_low(cvl), .special_event_trigger(trig),
    .aux_oscillator_enable(aux), .irq(irq), .wake(wake));
  tpc_cmp_model cmp_u (.clk(clk), .reset(reset), .cfg_mode(cfg_mode),
    .cfg_value(cfg_value), .compare_mode_field(cmode),
    .compare_value_high(cvh), .compare_value_low(cvl));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) if (trig === 1'b1) trig_cnt++;

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= {2'h0, idx, 2'h0}; pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin n_errors++; wrap_up(); end
    rdv = prdata; errv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rdv, {24'h000000, exp});
  endtask
  // gap in clocks between two successive trigger pulses
  task automatic trig_gap(output int gap);
    int s, n;
    s = trig_cnt; n = 0;
    while (trig_cnt == s && n < 400) begin @(posedge clk); n++; end
    s = trig_cnt; gap = 0;
    while (trig_cnt == s && gap < 400) begin @(posedge clk); gap++; end
    if (n >= 400 || gap >= 400) begin n_errors++; wrap_up(); end
  endtask
  task automatic ext_lvl(input logic v);
    ext_clk <= v;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_resets();
    rd_chk(IDX_COUNTER_CTRL, 8'h00);
    rd_chk(IDX_PERIPH_FLAGS, 8'h00);
    apb(1'b1, IDX_COUNTER_CTRL, 8'h3C);
    apb(1'b1, IDX_COUNTER_LOW, 8'h5A);
    apb(1'b1, IDX_COUNTER_HIGH, 8'hA5);
    other_reset <= 1'b1;
    @(posedge clk);
    other_reset <= 1'b0;
    rd_chk(IDX_COUNTER_CTRL, 8'h3C);
    chk({31'h0, aux}, 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_chk(IDX_COUNTER_CTRL, 8'h00);
    rd_chk(IDX_COUNTER_LOW, 8'h5A);
    rd_chk(IDX_COUNTER_HIGH, 8'hA5);
    apb(1'b0, 8'h0D, 8'h00);
    chk({31'h0, errv}, 32'h1);
    chk(rdv, 32'h0);
  endtask
  task automatic t_period();
    cfg_value <= 16'h0004; cfg_mode <= SPECIAL_EVENT_MODE;
    apb(1'b1, IDX_COUNTER_LOW, 8'h00);
    apb(1'b1, IDX_COUNTER_HIGH, 8'h00);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, IDX_COUNTER_CTRL, {2'h0, p[1:0], 4'h1});
      trig_gap(g);
      chk(g, 5 << p);
    end
    rd_chk(IDX_PERIPH_FLAGS, 8'h00);
  endtask
  // 1:8 ratio, writes every 3 clocks: no tick, so no trigger at compare 0
  task automatic t_prescale_clear();
    int s;
    cfg_value <= 16'h0000;
    repeat (12) apb(1'b1, IDX_COUNTER_LOW, 8'h00);
    s = trig_cnt;
    repeat (10) apb(1'b1, IDX_COUNTER_LOW, 8'h00);
    chk(trig_cnt - s, 0);
  endtask
  task automatic t_overflow();
    cfg_mode <= 4'h0;
    apb(1'b1, IDX_COUNTER_CTRL, 8'h00);
    apb(1'b1, IDX_COUNTER_LOW, 8'hF0);
    apb(1'b1, IDX_COUNTER_HIGH, 8'hFF);
    apb(1'b1, IDX_GLOBAL_IRQ_CTRL, 8'hC0);
    apb(1'b1, IDX_COUNTER_CTRL, 8'h01);
    repeat (40) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, IDX_PERIPH_ENABLES, 8'h01);
    chk({30'h0, irq, wake}, 32'h3);
    rd_chk(IDX_PERIPH_FLAGS, 8'h01);
    chk({31'h0, irq}, 32'h0);
    rd_chk(IDX_PERIPH_FLAGS, 8'h00);
  endtask
  // rise before any fall is ignored; async counts in sleep, sync stalls
  task automatic t_external();
    apb(1'b1, IDX_COUNTER_CTRL, 8'h03);
    apb(1'b1, IDX_COUNTER_LOW, 8'h00);
    apb(1'b1, IDX_COUNTER_HIGH, 8'h00);
    ext_lvl(1'b1);
    ext_lvl(1'b0);
    ext_lvl(1'b1);
    rd_chk(IDX_COUNTER_LOW, 8'h01);
    apb(1'b1, IDX_COUNTER_CTRL, 8'h07);
    slp <= 1'b1;
    repeat (2) begin ext_lvl(1'b0); ext_lvl(1'b1); end
    rd_chk(IDX_COUNTER_LOW, 8'h03);
    apb(1'b1, IDX_COUNTER_CTRL, 8'h03);
    ext_lvl(1'b0);
    ext_lvl(1'b1);
    rd_chk(IDX_COUNTER_LOW, 8'h03);
    slp <= 1'b0;
    apb(1'b1, IDX_COUNTER_CTRL, 8'h00);
  endtask

  initial begin
    reset = 1'b1; other_reset = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF;
    cfg_mode = 4'h0; cfg_value = 16'hFFFF; ext_clk = 1'b0; slp = 1'b0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_resets();
    t_period();
    t_prescale_clear();
    t_overflow();
    t_external();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
